// ===== rtl/dacu_ctrl.sv
// dac update controller: bus decode, acknowledge, double-buffered latches
// Behaviour
// RL1 - each of the sixteen channels has its own 12-bit converter latch pair.
// RL2 - every channel has an input and an output latch, with the mode picked by a register write.
// RL3 - in transparent mode a channel write goes straight through to the output latch.
// RL4 - in simultaneous mode writes load only input latches and outputs hold.
// RL5 - the trigger command copies all input latches into output latches at one edge.
// RL6 - io and id space addresses are decoded into converter, register and id selects.
// RL7 - every decoded access is acknowledged with wait states fitted to its target.
// RL8 - the selected mode is tracked and conversion starts are issued to match it.
// RL9 - all transfers use the 16-bit host data bus.
// RL10 - reset clears only output latches to bipolar zero, input latches keep their data.
// RL11 - the host waits at least 2 us before touching the same channel after a write.
// RL12 - a channel write during a pending trigger is stretched until the trigger lands.
// RL13 - channel data is 12 bits left-justified, low four bits ignored on writes.
// RL14 - id space is read only and writes there are acknowledged with no effect.
`timescale 1ns/1ps
`default_nettype none
`include "dacu_defs.svh"
// host cycles run on the carrier clock itself, so no synchroniser stages
module dacu_ctrl (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic io_sel_i,
  input wire logic id_sel_i,
  input wire logic wr_i,
  input wire logic [5:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic [7:0] cal_data_i,
  input wire logic [7:0] id_data_i,
  output logic [15:0] data_o,
  output logic ack_o,
  output logic cal_cs_o,
  output logic id_cs_o,
  output logic simul_mode_o,
  output logic [15:0] dac_load_o,
  output logic [191:0] dac_code_o
);
  dacu_pkg::dacu_state_t state;
  dacu_pkg::dacu_req_t req;
  logic [11:0] in_latch [0:15];
  logic [11:0] out_latch [0:15];
  logic simul_mode;
  logic trig_pend;
  logic [2:0] trig_cnt;
  logic [1:0] wait_cnt;
  logic [3:0] ch;
  logic is_ch;
  logic trig_fire;
  logic at_accept;

  assign req = '{io_sel: io_sel_i, id_sel: id_sel_i, wr: wr_i, addr: addr_i, data: data_i}; // RL9
  assign ch = req.addr[3:0];

  function automatic logic dec_ch(input logic [5:0] a);
    dec_ch = (a <= `DACU_ADDR_CH_LAST);
  endfunction

  function automatic logic dec_cal(input logic [5:0] a);
    dec_cal = (a >= `DACU_ADDR_CAL_BASE);
  endfunction

  assign is_ch = req.io_sel && dec_ch(req.addr); // RL6
  assign trig_fire = trig_pend && (trig_cnt == 3'h0);
  // the one edge at which a waited access takes effect
  assign at_accept = state == dacu_pkg::ST_WAIT && wait_cnt == 2'h0;

  // access sequencer
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state <= dacu_pkg::ST_IDLE;
      wait_cnt <= 2'h0;
      ack_o <= 1'b0;
    end
    else
    begin
      // ack defaults low, making it a one-cycle pulse
      ack_o <= 1'b0;
      case (state)
        dacu_pkg::ST_IDLE:
        begin
          if (req.id_sel)
          begin
            wait_cnt <= `DACU_WAIT_ID; // RL7
            state <= dacu_pkg::ST_WAIT;
          end
          else if (req.io_sel)
          begin
            wait_cnt <= is_ch ? `DACU_WAIT_DAC : `DACU_WAIT_REG; // RL7
            state <= dacu_pkg::ST_WAIT;
          end
        end
        dacu_pkg::ST_WAIT:
        begin
          // a channel write cannot overtake a pending trigger
          if (is_ch && req.wr && trig_pend)
            state <= dacu_pkg::ST_WAIT; // RL12
          else if (wait_cnt != 2'h0)
            wait_cnt <= wait_cnt - 2'h1;
          else
          begin
            ack_o <= 1'b1; // RL7
            state <= dacu_pkg::ST_DONE;
          end
        end
        dacu_pkg::ST_DONE:
        begin
          // hold off until the host drops its select
          if (!req.io_sel && !req.id_sel)
            state <= dacu_pkg::ST_IDLE;
        end
        default:
          state <= dacu_pkg::ST_IDLE;
      endcase
    end
  end

  // mode register and trigger timing
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      simul_mode <= 1'b0;
      trig_pend <= 1'b0;
      trig_cnt <= 3'h0;
    end
    else
    begin
      // mode clears to transparent so a reset never leaves outputs staged
      if (at_accept && req.io_sel && req.wr)
      begin
        if (req.addr == `DACU_ADDR_MODE_TRANS)
          simul_mode <= 1'b0; // RL2
        else if (req.addr == `DACU_ADDR_MODE_SIMUL)
          simul_mode <= 1'b1; // RL2
      end
      if (trig_fire)
        trig_pend <= 1'b0;
      // a trigger that arrives while one is pending is dropped, not queued
      else if (at_accept && req.io_sel && req.wr && req.addr == `DACU_ADDR_TRIG && !trig_pend)
      begin
        trig_pend <= 1'b1; // RL8
        trig_cnt <= `DACU_TRIG_DELAY;
      end
      else if (trig_pend)
        trig_cnt <= trig_cnt - 3'h1;
    end
  end

  // latch pairs, one per channel
  genvar g;
  generate
    for (g = 0; g < `DACU_NUM_CH; g = g + 1)
    begin : gen_ch
      logic wr_hit;
      assign wr_hit = at_accept && is_ch && req.wr && !trig_pend
                      && ch == 4'(g); // RL6
      // input latch has no reset on purpose
      always_ff @(posedge clk_sys_i)
      begin
        if (wr_hit)
          in_latch[g] <= req.data[15:4]; // RL13
      end
      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          out_latch[g] <= `DACU_ZERO_CODE; // RL10
          dac_load_o[g] <= 1'b0;
        end
        else
        begin
          dac_load_o[g] <= 1'b0;
          if (trig_fire)
          begin
            out_latch[g] <= in_latch[g]; // RL5
            dac_load_o[g] <= 1'b1; // RL8
          end
          else if (wr_hit && !simul_mode) // RL4
          begin
            out_latch[g] <= req.data[15:4]; // RL3
            dac_load_o[g] <= 1'b1; // RL3
          end
          // RL4 simultaneous writes leave out_latch alone
        end
      end
      assign dac_code_o[g*12 +: 12] = out_latch[g]; // RL1
    end
  endgenerate

  // read data and storage selects; id writes fall through with no effect
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      data_o <= 16'h0000;
      cal_cs_o <= 1'b0;
      id_cs_o <= 1'b0;
      simul_mode_o <= 1'b0;
    end
    else
    begin
      simul_mode_o <= simul_mode;
      id_cs_o <= req.id_sel && !req.wr; // RL14
      cal_cs_o <= req.io_sel && !req.wr && dec_cal(req.addr); // RL6
      // read data is refreshed every cycle, so it stands by the ack edge
      if (req.id_sel)
        data_o <= {8'h00, id_data_i}; // RL14
      else if (is_ch)
        data_o <= {in_latch[ch], 4'h0}; // RL13
      else if (req.addr == `DACU_ADDR_MODE_READ)
        data_o <= {15'h0, simul_mode};
      else if (dec_cal(req.addr))
        data_o <= {8'h00, cal_data_i};
      else
        data_o <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ===== inc/dacu_defs.svh
// constants for the dac update controller
`ifndef DACU_DEFS_SVH
`define DACU_DEFS_SVH
`define DACU_NUM_CH 16
`define DACU_DAC_W 12
`define DACU_BUS_W 16
`define DACU_ZERO_CODE 12'h800
`define DACU_ADDR_CH_LAST 6'h0F
`define DACU_ADDR_MODE_TRANS 6'h10
`define DACU_ADDR_MODE_SIMUL 6'h11
`define DACU_ADDR_TRIG 6'h12
`define DACU_ADDR_MODE_READ 6'h13
`define DACU_ADDR_CAL_BASE 6'h20
`define DACU_CAL_DEPTH 64
`define DACU_WAIT_REG 2'h1
`define DACU_WAIT_DAC 2'h1
`define DACU_WAIT_ID 2'h0
`define DACU_TRIG_DELAY 3'h4
`endif

// ===== inc/dacu_pkg.sv
// types for the dac update controller
package dacu_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_ACK = 2'b10,
    ST_DONE = 2'b11
  } dacu_state_t;
  typedef struct packed {
    logic io_sel;
    logic id_sel;
    logic wr;
    logic [5:0] addr;
    logic [15:0] data;
  } dacu_req_t;
endpackage

// ===== bench/dacu_checker.sv
// port assertions for the dac update controller
`timescale 1ns/1ps
`default_nettype none
module dacu_checker (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic io_sel_i,
  input wire logic id_sel_i,
  input wire logic wr_i,
  input wire logic [5:0] addr_i,
  input wire logic ack_o,
  input wire logic id_cs_o,
  input wire logic cal_cs_o,
  input wire logic simul_mode_o,
  input wire logic [15:0] dac_load_o,
  input wire logic [191:0] dac_code_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  AST_ID_ACK: assert property ($rose(id_sel_i) |-> ##2 ack_o)
    else $error("id ack late");
  AST_REG_ACK: assert property ($rose(io_sel_i) && addr_i > 6'h0F |-> ##3 ack_o)
    else $error("reg ack late");
  AST_TRANS: assert property ($rose(io_sel_i) && wr_i && addr_i <= 6'h0F && !simul_mode_o
    |-> ##3 dac_load_o == 16'h0001 << addr_i)
    else $error("no channel load");
  AST_SIM_ALL: assert property (simul_mode_o && dac_load_o != 16'h0 |-> dac_load_o == 16'hFFFF)
    else $error("partial load");
  AST_CODE_LOAD: assert property ($changed(dac_code_o)
    |-> (dac_load_o | $past(dac_load_o)) != 16'h0)
    else $error("code moved unloaded");
  AST_RST_ZERO: assert property (disable iff (1'b0) rst_i |=> dac_code_o == {16{12'h800}})
    else $error("reset code");
  AST_MODE: assert property ($rose(io_sel_i) && wr_i && addr_i inside {6'h10, 6'h11}
    |-> ##4 simul_mode_o == $past(addr_i[0], 4))
    else $error("mode");
  AST_ID_RO: assert property ($rose(id_sel_i) && wr_i
    |=> ($stable(simul_mode_o) && dac_load_o == 16'h0) [*3])
    else $error("id write acted");
  AST_ID_CS: assert property (id_cs_o == $past(id_sel_i && !wr_i))
    else $error("id select wrong");
  AST_CAL_CS: assert property (cal_cs_o == $past(io_sel_i && !wr_i && addr_i >= 6'h20))
    else $error("cal select wrong");
  cover property ($rose(io_sel_i) && wr_i && addr_i == 6'h12);
  cover property (dac_load_o == 16'hFFFF);
  cover property ($rose(id_sel_i) && wr_i);
endmodule
bind dacu_ctrl dacu_checker dacu_checker_i (.clk_sys_i, .rst_i, .io_sel_i, .id_sel_i, .wr_i,
  .addr_i, .ack_o, .id_cs_o, .cal_cs_o, .simul_mode_o, .dac_load_o, .dac_code_o);
`default_nettype wire

// ===== bench/dacu_host.sv
// carrier host model issuing io and id space cycles
`timescale 1ns/1ps
`default_nettype none
module dacu_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [15:0] rdata_i,
  output logic io_sel_o,
  output logic id_sel_o,
  output logic wr_o,
  output logic [5:0] addr_o,
  output logic [15:0] data_o
);
  initial {io_sel_o, id_sel_o, wr_o, addr_o, data_o} = '0;
  task automatic xfer(input logic id, input logic w, input logic [5:0] a,
    input logic [15:0] d, output logic [15:0] q, output int n);
    n = 0;
    @(negedge clk_i);
    {io_sel_o, id_sel_o, wr_o, addr_o, data_o} = {!id, id, w, a, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 40);
    q = rdata_i;
    @(negedge clk_i);
    {io_sel_o, id_sel_o, wr_o} = 3'h0;
    {addr_o, data_o} = ~{a, d}; // idle bus driven with inverted address and data, no stale value
    if (w && !id && a <= 6'h0F)
      repeat (250) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== bench/dacu_ctrl_bench.sv
// self-checking bench for the dac update controller
`timescale 1ns/1ps
`default_nettype none
module dacu_ctrl_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] cal_data_i = 8'h5A;
  logic [7:0] id_data_i = 8'hC3;
  logic io_sel_i, id_sel_i, wr_i, ack_o, cal_cs_o, id_cs_o, simul_mode_o;
  logic [5:0] addr_i;
  logic [15:0] data_i, data_o, dac_load_o, q;
  logic [191:0] dac_code_o;
  int miscompares = 0;
  int check_count = 0;
  int n;
  initial
    forever #4 clk_sys_i = ~clk_sys_i;
  dacu_host dacu_host_i (.clk_i(clk_sys_i), .ack_i(ack_o), .rdata_i(data_o),
    .io_sel_o(io_sel_i), .id_sel_o(id_sel_i), .wr_o(wr_i), .addr_o(addr_i), .data_o(data_i));
  dacu_ctrl dacu_ctrl_i (.clk_sys_i, .rst_i, .io_sel_i, .id_sel_i, .wr_i, .addr_i, .data_i,
    .cal_data_i, .id_data_i, .data_o, .ack_o, .cal_cs_o, .id_cs_o, .simul_mode_o,
    .dac_load_o, .dac_code_o);
  task automatic x(input logic id, input logic w, input logic [5:0] a, input logic [15:0] d);
    dacu_host_i.xfer(id, w, a, d, q, n);
    chk(n < 40, 1'b1);
  endtask
  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_trans();
    chk(dac_code_o, {16{12'h800}});
    x(0, 1, 6'h03, 16'hABCF);
    chk(n, 4);
    chk(dac_code_o[36+:12], 12'hABC);
    x(0, 1, 6'h06, 16'h7770);
    x(0, 0, 6'h03, 0);
    chk(q, 16'hABC0);
    $display("trans done");
  endtask
  task automatic t_simul();
    x(0, 1, 6'h11, 0);
    x(0, 1, 6'h05, 16'h1230);
    chk(dac_code_o[60+:12], 12'h800);
    x(0, 1, 6'h12, 0);
    x(0, 1, 6'h06, 16'h4560);
    chk(n, 6);
    chk(dac_code_o[60+:12], 12'h123);
    chk(dac_code_o[36+:12], 12'hABC);
    chk(dac_code_o[72+:12], 12'h777);
    x(0, 0, 6'h06, 0);
    chk(q, 16'h4560);
    x(0, 0, 6'h13, 0);
    chk(q, 16'h0001);
    $display("simul done");
  endtask
  task automatic t_id();
    x(1, 0, 6'h00, 0);
    chk(n, 3);
    chk(q[7:0], id_data_i);
    x(1, 1, 6'h10, 16'hFFFF);
    chk(simul_mode_o, 1'b1);
    x(0, 0, 6'h20, 0);
    chk(q[7:0], cal_data_i);
    x(0, 0, 6'h18, 0);
    chk(q, 16'h0000);
    $display("id done");
  endtask
  task automatic t_reset2();
    @(negedge clk_sys_i) rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk(dac_code_o, {16{12'h800}});
    chk(simul_mode_o, 1'b0);
    x(0, 1, 6'h11, 0);
    x(0, 1, 6'h12, 0);
    repeat (8) @(negedge clk_sys_i);
    chk(dac_code_o[60+:12], 12'h123);
    $display("reset done");
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i) rst_i = 1'b0;
    t_trans();
    t_simul();
    t_id();
    t_reset2();
    end_of_test();
  end
  initial
  begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
